// *** include/eac_pkg.sv ***
package eac_pkg;

  // Bit numbering: the register is shown big-endian, so bit 0 is the msb.
  localparam int EAC_REG_W = 32;
  localparam int EAC_ENABLE_POS = 31;
  localparam int EAC_RID_LSB = 0;
  localparam int EAC_RID_W = 6;
  localparam int EAC_RID_IMPL_W = 4;
  localparam logic [31:0] EAC_RESET_VAL = 32'h0000_0000;
  localparam logic [31:0] EAC_WRITE_MASK = 32'h8000_003f;
  localparam logic [3:0] EAC_ACCESS_MODE = 4'h5;
  localparam logic [9:0] EAC_SPR_NUM = 10'h11a;

  typedef struct packed {
    logic valid;
    logic is_out;
    logic [31:0] phys_addr;
    logic [31:0] wdata;
  } eac_ext_req_s;

  typedef struct packed {
    logic valid;
    logic [9:0] spr;
    logic wr;
    logic supervisor;
    logic [31:0] wdata;
  } eac_spr_req_s;

  typedef struct packed {
    logic mtmsr;
    logic alters_pow_le;
    logic other_alter;
    logic sync_instr;
    logic exception;
    logic nonrecoverable;
    logic rfi;
  } eac_ctx_s;

  typedef enum logic [1:0] {
    EAC_CTX_OLD = 2'b00,
    EAC_CTX_WINDOW = 2'b01,
    EAC_CTX_NEW = 2'b10
  } eac_ctx_e;

endpackage : eac_pkg

// *** design/eac_ctrl.sv ***
// Notes on behaviour
// - 32-bit register, enable bit 0, ID bits 26-31.
// - Enable gates external ops; clear raises storage fault.
// - Unsupported high ID bits never select devices.
// - External accesses use fixed access mode 0101.
// - Register access only at supervisor via special moves.
// - Pass address and out-data to selected device.
// - Recoverable exceptions act as context synchronization.
// - Sync before alteration keeps old context.
// - Sync after alteration gives new context.
// - Between syncs either context is acceptable.
// - Preceding instructions decoded before altering executes.
// - Altering instruction is sync point when none needed.
module eac_ctrl
  import eac_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire eac_spr_req_s spr_req_i,
  input wire eac_ext_req_s ext_req_i,
  input wire eac_ctx_s ctx_i,
  output logic [31:0] spr_rdata_o,
  output logic spr_priv_fault_o,
  output logic ext_valid_o,
  output logic ext_is_out_o,
  output logic [31:0] ext_addr_o,
  output logic [31:0] ext_wdata_o,
  output logic [EAC_RID_IMPL_W-1:0] ext_target_o,
  output logic [3:0] ext_mode_o,
  output logic dsi_o,
  output logic ctx_sync_o,
  output logic [1:0] ctx_state_o
);

  logic [31:0] access_reg;
  eac_ctx_e ctx_state;
  eac_ctx_e next_ctx_state;

  wire spr_hit = spr_req_i.valid && (spr_req_i.spr == EAC_SPR_NUM);
  wire spr_ok = spr_hit && spr_req_i.supervisor;
  wire spr_wr = spr_ok && spr_req_i.wr;
  wire enable = access_reg[EAC_ENABLE_POS];
  wire [EAC_RID_IMPL_W-1:0] target_resource_id =
    access_reg[EAC_RID_LSB +: EAC_RID_IMPL_W];
  wire go = ext_req_i.valid && enable;
  wire fault = ext_req_i.valid && !enable;
  // A nonrecoverable reset or machine check may lose state, so it is no sync point.
  wire recoverable_exc = ctx_i.exception && !ctx_i.nonrecoverable;
  // Recoverable exceptions, rfi and explicit syncs all close a context window.
  wire sync_evt = ctx_i.sync_instr || ctx_i.rfi || recoverable_exc;
  // A machine-state move serialises itself unless power or endian bits change.
  wire self_sync = ctx_i.mtmsr && !ctx_i.alters_pow_le;
  // Writing the access register is itself an alteration for later data accesses.
  wire alter = ctx_i.mtmsr || ctx_i.other_alter || spr_wr;
  wire open_window = alter && !self_sync;
  wire self_close = alter && self_sync;

  always_comb begin
    next_ctx_state = ctx_state;
    case (ctx_state)
      EAC_CTX_OLD: begin
        // Older instructions are already decoded, so an alteration that is not self-synchronising opens the window.
        if (open_window) begin
          next_ctx_state = EAC_CTX_WINDOW;
        end else if (self_close) begin
          next_ctx_state = EAC_CTX_NEW;
        end
      end
      EAC_CTX_WINDOW: begin
        // Either context is legal here; only a sync event settles on the new one.
        if (sync_evt) begin
          next_ctx_state = EAC_CTX_NEW;
        end
      end
      EAC_CTX_NEW: begin
        if (open_window) begin
          next_ctx_state = EAC_CTX_WINDOW;
        end else if (self_close) begin
          next_ctx_state = EAC_CTX_NEW;
        end else begin
          next_ctx_state = EAC_CTX_OLD;
        end
      end
      default: begin
        next_ctx_state = EAC_CTX_OLD;
      end
    endcase
  end

  // Only the enable and the identifier field are stored; the rest read back as zero.
  wire [31:0] next_access_reg = spr_req_i.wdata & EAC_WRITE_MASK;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctx_state <= EAC_CTX_OLD;
    end else begin
      ctx_state <= next_ctx_state;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      access_reg <= EAC_RESET_VAL;
    end else if (spr_wr) begin
      access_reg <= next_access_reg;
    end
  end

  // Idle address, word, mode and read-data outputs are forced to zero so the device never sees a stale address or word.
  wire spr_rd = spr_ok && !spr_req_i.wr;
  wire fwd_out = go && ext_req_i.is_out;
  wire [31:0] next_spr_rdata = spr_rd ? access_reg : 32'h0000_0000;
  wire next_priv_fault = spr_hit && !spr_req_i.supervisor;
  wire [31:0] next_ext_addr = go ? ext_req_i.phys_addr : 32'h0000_0000;
  wire [31:0] next_ext_wdata = fwd_out ? ext_req_i.wdata : 32'h0000_0000;
  wire [3:0] next_ext_mode = go ? EAC_ACCESS_MODE : 4'h0;
  // A self-synchronising move reports its own sync point, as a sync event does.
  wire next_ctx_sync = sync_evt || self_close;

  // Reads return the whole register; the write mask already zeroes reserved bits.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      spr_rdata_o <= 32'h0000_0000;
    end else begin
      spr_rdata_o <= next_spr_rdata;
    end
  end

  // A user-level access is refused and leaves the register untouched.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      spr_priv_fault_o <= 1'b0;
    end else begin
      spr_priv_fault_o <= next_priv_fault;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_valid_o <= 1'b0;
    end else begin
      ext_valid_o <= go;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_is_out_o <= 1'b0;
    end else begin
      ext_is_out_o <= fwd_out;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_addr_o <= 32'h0000_0000;
    end else begin
      ext_addr_o <= next_ext_addr;
    end
  end

  // The word only means something to the device on an output instruction.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_wdata_o <= 32'h0000_0000;
    end else begin
      ext_wdata_o <= next_ext_wdata;
    end
  end

  // The target follows the register at all times; only the valid pulse marks a request.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_target_o <= '0;
    end else begin
      ext_target_o <= target_resource_id;
    end
  end

  // The access mode is fixed and ignores whatever the page attributes say.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_mode_o <= 4'h0;
    end else begin
      ext_mode_o <= next_ext_mode;
    end
  end

  // A disabled request raises the storage fault instead of reaching the device.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dsi_o <= 1'b0;
    end else begin
      dsi_o <= fault;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctx_sync_o <= 1'b0;
    end else begin
      ctx_sync_o <= next_ctx_sync;
    end
  end

  // The state is published as its binary code: zero old, one window, two new.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctx_state_o <= 2'h0;
    end else begin
      ctx_state_o <= next_ctx_state;
    end
  end

endmodule : eac_ctrl

// *** test/eac_ctrl_assertions.sv ***
module eac_ctrl_assertions
  import eac_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire eac_spr_req_s spr_req_i,
  input wire eac_ext_req_s ext_req_i,
  input wire logic [31:0] spr_rdata_o,
  input wire logic spr_priv_fault_o,
  input wire logic ext_valid_o,
  input wire logic ext_is_out_o,
  input wire logic [31:0] ext_addr_o,
  input wire logic [31:0] ext_wdata_o,
  input wire logic [3:0] ext_mode_o,
  input wire logic dsi_o,
  input wire eac_ctx_s ctx_i,
  input wire logic ctx_sync_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence fwd_s;
    ext_req_i.valid ##1 ext_valid_o;
  endsequence
  sequence fwd_out_s;
    fwd_s ##0 ext_is_out_o;
  endsequence
  AST_MODE: assert property (ext_valid_o |-> ext_mode_o == EAC_ACCESS_MODE)
    else $error("mode");
  AST_ANS: assert property (ext_req_i.valid |=> ext_valid_o != dsi_o)
    else $error("answer");
  AST_IDLE: assert property (!ext_req_i.valid |=> !ext_valid_o && !dsi_o)
    else $error("idle");
  AST_ADDR: assert property (fwd_s |-> ext_addr_o == $past(ext_req_i.phys_addr))
    else $error("addr");
  AST_DIR: assert property (fwd_s |-> ext_is_out_o == $past(ext_req_i.is_out))
    else $error("dir");
  AST_WORD: assert property (fwd_out_s |-> ext_wdata_o == $past(ext_req_i.wdata))
    else $error("word");
  AST_PRIV: assert property (
    spr_req_i.valid && spr_req_i.spr == EAC_SPR_NUM && !spr_req_i.supervisor
    |=> spr_priv_fault_o) else $error("priv");
  AST_RSV: assert property ((spr_rdata_o & ~EAC_WRITE_MASK) == 32'h0)
    else $error("reserved");
  AST_SYNC: assert property (ctx_i.sync_instr || ctx_i.rfi |=> ctx_sync_o)
    else $error("sync");
  AST_EXC: assert property (ctx_i.exception && !ctx_i.nonrecoverable |=> ctx_sync_o)
    else $error("exception");
endmodule : eac_ctrl_assertions

// *** test/eac_dev_model.sv ***
module eac_dev_model (
  input wire logic core_clk_i,
  input wire logic ext_valid_i,
  input wire logic ext_is_out_i,
  input wire logic [31:0] ext_addr_i,
  input wire logic [31:0] ext_wdata_i,
  output logic [31:0] last_addr_o,
  output logic [31:0] last_word_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // The device alone gives address and word a meaning, so it only keeps the last ones.
  always_ff @(posedge core_clk_i) begin
    if (ext_valid_i) begin
      last_addr_o <= ext_addr_i;
    end
    if (ext_valid_i && ext_is_out_i) begin
      last_word_o <= ext_wdata_i;
    end
  end
endmodule : eac_dev_model

// *** test/testbench.sv ***
module testbench
  import eac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'h0, nrst_i = 1'h0, pf, ev, io, ds, cs;
  logic [1:0] cst;
  eac_ctx_s c = '0;
  logic [31:0] la, lw;
  eac_spr_req_s s = '0;
  eac_ext_req_s e = '0;
  logic [31:0] rd, ad, wd;
  logic [3:0] tg, md;
  int fail_count = 0, n_tests = 0;
  eac_ctrl eac_ctrl_i(.core_clk_i, .nrst_i, .spr_req_i(s), .ext_req_i(e), .ctx_i(c),
    .spr_rdata_o(rd), .spr_priv_fault_o(pf), .ext_valid_o(ev), .ext_is_out_o(io),
    .ext_addr_o(ad), .ext_wdata_o(wd), .ext_target_o(tg), .ext_mode_o(md), .dsi_o(ds),
    .ctx_sync_o(cs), .ctx_state_o(cst));
  eac_dev_model eac_dev_model_i(.core_clk_i, .ext_valid_i(ev), .ext_is_out_i(io),
    .ext_addr_i(ad), .ext_wdata_i(wd), .last_addr_o(la), .last_word_o(lw));
  initial forever #4 core_clk_i = ~core_clk_i;
  task chk(string n, logic [31:0] x, logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h got %h", n, x, g);
    end
  endtask : chk
  task go(logic v, logic w, logic u, logic [31:0] d, eac_ext_req_s b);
    @(posedge core_clk_i);
    #1 s = '{v, EAC_SPR_NUM, w, u, d};
    e = b;
    @(posedge core_clk_i);
    #1 s = '0;
    e = '0;
  endtask : go
  task cx(eac_ctx_s b);
    @(posedge core_clk_i);
    #1 c = b;
    @(posedge core_clk_i);
    #1 c = '0;
  endtask : cx
  task end_of_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (5) @(posedge core_clk_i);
    #1 nrst_i = 1'h1;
    go(1'h1, 1'h0, 1'h1, 32'h0, '0); chk("reset", 32'h0, rd);
    go(1'h1, 1'h1, 1'h0, '1, '0); chk("fault", 32'h1, {31'h0, pf});
    go(1'h1, 1'h0, 1'h1, 32'h0, '0); chk("kept", 32'h0, rd);
    go(1'h1, 1'h1, 1'h1, '1, '0);
    go(1'h1, 1'h0, 1'h1, 32'h0, '0); chk("mask", 32'h8000_003f, rd);
    $display("register test done");
    go(1'h1, 1'h1, 1'h1, 32'h8000_0033, '0);
    go(1'h0, 1'h0, 1'h0, 32'h0, '{1'h1, 1'h1, 32'h1234_5678, 32'h0bad_f00d});
    chk("target", 32'h3, {28'h0, tg});
    chk("mode", 32'h5, {28'h0, md});
    chk("addr", 32'h1234_5678, ad);
    chk("word", 32'h0bad_f00d, wd);
    chk("dir", 32'h1, {31'h0, io});
    go(1'h0, 1'h0, 1'h0, 32'h0, '{1'h1, 1'h0, 32'h2000, 32'hffff_ffff});
    chk("in op", 32'h2, {30'h0, ev, io});
    chk("in word", 32'h0, wd);
    $display("forward test done");
    go(1'h1, 1'h1, 1'h1, 32'h0, '0);
    go(1'h0, 1'h0, 1'h0, 32'h0, '{1'h1, 1'h0, 32'h40, 32'h0});
    chk("dsi", 32'h1, {30'h0, ev, ds});
    chk("dev addr", 32'h2000, la);
    chk("dev word", 32'h0bad_f00d, lw);
    $display("disable test done");
    chk("window", 32'h2, {29'h0, cst, cs});
    cx(7'h08); chk("sync", 32'h5, {29'h0, cst, cs});
    cx(7'h40); chk("mtmsr", 32'h5, {29'h0, cst, cs});
    cx(7'h60); chk("pow le", 32'h2, {29'h0, cst, cs});
    cx(7'h06); chk("lost exc", 32'h2, {29'h0, cst, cs});
    cx(7'h04); chk("exc", 32'h5, {29'h0, cst, cs});
    cx(7'h10); chk("alter", 32'h2, {29'h0, cst, cs});
    cx(7'h01); chk("rfi", 32'h5, {29'h0, cst, cs});
    $display("context test done");
    go(1'h1, 1'h1, 1'h1, 32'h8000_0001, '0);
    @(posedge core_clk_i);
    #1 nrst_i = 1'h0;
    @(posedge core_clk_i);
    #1 nrst_i = 1'h1;
    go(1'h1, 1'h0, 1'h1, 32'h0, '0); chk("reset reg", 32'h0, rd);
    chk("reset ctx", 32'h0, {29'h0, cst, cs});
    go(1'h0, 1'h0, 1'h0, 32'h0, '{1'h1, 1'h1, 32'h80, 32'h1});
    chk("reset dsi", 32'h1, {30'h0, ev, ds});
    $display("reset test done");
    end_of_test();
  end
endmodule : testbench
bind eac_ctrl eac_ctrl_assertions eac_ctrl_assertions_i(.core_clk_i, .nrst_i, .spr_req_i,
  .ext_req_i, .spr_rdata_o, .spr_priv_fault_o, .ext_valid_o, .ext_is_out_o, .ext_addr_o,
  .ext_wdata_o, .ext_mode_o, .dsi_o, .ctx_i, .ctx_sync_o);
